// [core/pbc_pkg.sv]
package pbc_pkg;
	// Register index of the basic mode control word on the management bus
	localparam logic [4:0] BMC_OFFSET = 5'h00;
	// Field positions inside the control word
	localparam int ISOLATE_POS = 10;
	localparam int RESTART_POS = 9;
	localparam int DUPLEX_POS = 8;
	localparam int COLTEST_POS = 7;
	localparam int HI_LSB_POS = 11;
	localparam int RSVD_W = 7;
	// Reset values of the fields
	localparam logic ISOLATE_RST = 1'b1;
	localparam logic RESTART_RST = 1'b0;
	localparam logic DUPLEX_RST = 1'b1;
	localparam logic COLTEST_RST = 1'b0;
	localparam logic [4:0] STRAP_ZERO = 5'h00;
	// Management frame layout
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [4:0] HDR_LAST = 5'h0c;
	localparam logic [4:0] DATA_LAST = 5'h0f;
	// Cycles after reset release before the straps are trusted; the filter agrees only from the fourth edge on
	localparam logic [2:0] STRAP_WAIT = 3'h4;
	// Management frame receiver states, gray along the frame path
	typedef enum logic [1:0] {
		PBC_IDLE = 2'b00,
		PBC_HDR = 2'b01,
		PBC_TA = 2'b11,
		PBC_DATA = 2'b10
	} pbc_mgmt_state_t;
endpackage

// [core/pbc_mgmt_serial.sv]
`timescale 1ns/1ps
module pbc_mgmt_serial #(
	parameter int DATA_W = 16
) (
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	input wire logic en_i,
	input wire logic [4:0] phy_addr_i,
	input wire logic mdc_i,
	input wire logic mdio_i,
	input wire logic [DATA_W-1:0] rdata_i,
	output logic mdio_o,
	output logic mdio_oe_n_o,
	output logic wr_stb_o,
	output logic [DATA_W-1:0] wdata_o
);
	logic [1:0] s1_ff, s2_ff, s3_ff, filt_ff;
	logic mdc_old_ff, prev_one_ff, is_rd_ff, hit_ff;
	logic [12:0] hdr_ff;
	logic [DATA_W-1:0] sh_ff;
	logic [4:0] cnt_ff;
	pbc_pkg::pbc_mgmt_state_t st_ff;
	wire logic edge_w, bit_w, hdr_ok_w, addr_hit_w, reg_hit_w;
	wire logic [12:0] nxt_hdr;
	wire logic [1:0] op_w;

	// Pin samplers: a change counts once the second and third stages agree
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_sync
			always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
				if (!reset_n_i) begin
					s1_ff[gi] <= 1'b1;
					s2_ff[gi] <= 1'b1;
					s3_ff[gi] <= 1'b1;
					filt_ff[gi] <= 1'b1;
				end else begin
					s1_ff[gi] <= (gi == 0) ? mdc_i : mdio_i;
					s2_ff[gi] <= s1_ff[gi];
					s3_ff[gi] <= s2_ff[gi];
					if (s2_ff[gi] == s3_ff[gi])
						filt_ff[gi] <= s3_ff[gi];
				end
			end
		end
	endgenerate

	// Frame decode
	assign edge_w = filt_ff[0] & ~mdc_old_ff;
	assign bit_w = filt_ff[1];
	assign nxt_hdr = {hdr_ff[11:0], bit_w};
	assign op_w = nxt_hdr[11:10];
	assign hdr_ok_w = nxt_hdr[12] & ((op_w == pbc_pkg::OP_WRITE) | (op_w == pbc_pkg::OP_READ));
	assign addr_hit_w = hdr_ok_w & (nxt_hdr[9:5] == phy_addr_i);
	assign reg_hit_w = nxt_hdr[4:0] == pbc_pkg::BMC_OFFSET;

	// Bit engine, advanced once per rising management clock
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_ff <= pbc_pkg::PBC_IDLE;
			mdc_old_ff <= 1'b1;
			prev_one_ff <= 1'b0;
			is_rd_ff <= 1'b0;
			hit_ff <= 1'b0;
			hdr_ff <= '0;
			sh_ff <= '0;
			cnt_ff <= 5'h00;
			mdio_o <= 1'b1;
			mdio_oe_n_o <= 1'b1;
			wr_stb_o <= 1'b0;
			wdata_o <= '0;
		end else begin
			mdc_old_ff <= filt_ff[0];
			wr_stb_o <= 1'b0;
			if (edge_w) begin
				cnt_ff <= cnt_ff + 5'h01;
				unique case (st_ff)
					pbc_pkg::PBC_IDLE: begin
						prev_one_ff <= bit_w;
						cnt_ff <= 5'h00;
						if (en_i && prev_one_ff && !bit_w)
							st_ff <= pbc_pkg::PBC_HDR;
					end
					pbc_pkg::PBC_HDR: begin
						hdr_ff <= nxt_hdr;
						if (cnt_ff == pbc_pkg::HDR_LAST) begin
							cnt_ff <= 5'h00;
							prev_one_ff <= 1'b0;
							is_rd_ff <= op_w == pbc_pkg::OP_READ;
							hit_ff <= reg_hit_w;
							// Unmapped registers read as zero
							sh_ff <= reg_hit_w ? rdata_i : '0;
							st_ff <= addr_hit_w ? pbc_pkg::PBC_TA : pbc_pkg::PBC_IDLE;
						end
					end
					pbc_pkg::PBC_TA: begin
						if (is_rd_ff) begin
							mdio_oe_n_o <= 1'b0;
							mdio_o <= (cnt_ff == 5'h00) ? 1'b0 : sh_ff[DATA_W-1];
							if (cnt_ff != 5'h00)
								sh_ff <= {sh_ff[DATA_W-2:0], 1'b0};
						end
						if (cnt_ff != 5'h00) begin
							cnt_ff <= 5'h00;
							st_ff <= pbc_pkg::PBC_DATA;
						end
					end
					pbc_pkg::PBC_DATA: begin
						if (is_rd_ff) begin
							mdio_o <= sh_ff[DATA_W-1];
							sh_ff <= {sh_ff[DATA_W-2:0], 1'b0};
						end else begin
							sh_ff <= {sh_ff[DATA_W-2:0], bit_w};
						end
						if (cnt_ff == pbc_pkg::DATA_LAST) begin
							mdio_oe_n_o <= 1'b1;
							mdio_o <= 1'b1;
							wr_stb_o <= ~is_rd_ff & hit_ff;
							wdata_o <= {sh_ff[DATA_W-2:0], bit_w};
							st_ff <= pbc_pkg::PBC_IDLE;
						end
					end
				endcase
			end
		end
	end
endmodule

// [core/pbc_basic_control.sv]
`timescale 1ns/1ps
module pbc_basic_control (
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	input wire logic [4:0] station_address_straps_i,
	input wire logic mdc_i,
	input wire logic mdio_i,
	output logic mdio_o,
	output logic mdio_oe_n_o,
	input wire logic [4:0] ctrl_hi_i,
	input wire logic an_enable_i,
	input wire logic speed_sel_i,
	input wire logic an_started_i,
	input wire logic an_duplex_i,
	input wire logic an_speed_i,
	input wire logic ref_clk_en_i,
	input wire logic [3:0] txd_i,
	input wire logic tx_en_i,
	input wire logic tx_er_i,
	input wire logic [3:0] core_rxd_i,
	input wire logic core_rx_dv_i,
	input wire logic core_rx_er_i,
	input wire logic core_crs_i,
	input wire logic core_col_i,
	output logic [3:0] core_txd_o,
	output logic core_tx_en_o,
	output logic core_tx_er_o,
	output logic [3:0] mii_rxd_o,
	output logic mii_rx_dv_o,
	output logic mii_rx_er_o,
	output logic mii_crs_o,
	output logic mii_col_o,
	output logic mii_oe_n_o,
	output logic line_idle_o,
	output logic alt_tx_oe_n_o,
	output logic rx_ignore_o,
	output logic link_disable_o,
	output logic reference_clock_out_en_o,
	output logic an_restart_req_o,
	output logic full_duplex_o,
	output logic speed_100_o
);
	localparam int SYNC_W = 11;
	logic [SYNC_W-1:0] s1_ff, s2_ff, s3_ff, filt_ff;
	logic isolate_ff, restart_ff, duplex_ff, coltest_ff;
	logic strap_done_ff;
	logic [2:0] strap_cnt_ff;
	logic [4:0] phy_addr_ff;
	wire logic [SYNC_W-1:0] pins_w;
	wire logic [15:0] rd_word_w;
	wire logic [15:0] wdata_w;
	wire logic wr_stb_w, tx_en_w, strap_load_w;
	wire logic nxt_restart, nxt_isolate;

	// Pin samplers for straps and MII transmit inputs
	assign pins_w = {station_address_straps_i, tx_er_i, tx_en_i, txd_i};
	genvar gi;
	generate
		for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
			always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
				if (!reset_n_i) begin
					s1_ff[gi] <= 1'b0;
					s2_ff[gi] <= 1'b0;
					s3_ff[gi] <= 1'b0;
					filt_ff[gi] <= 1'b0;
				end else begin
					s1_ff[gi] <= pins_w[gi];
					s2_ff[gi] <= s1_ff[gi];
					s3_ff[gi] <= s2_ff[gi];
					if (s2_ff[gi] == s3_ff[gi])
						filt_ff[gi] <= s3_ff[gi];
				end
			end
		end
	endgenerate

	// Management frames keep working in isolate mode
	pbc_mgmt_serial #(
		.DATA_W(16)
	) u_mgmt (
		.ref_clk_i(ref_clk_i),
		.reset_n_i(reset_n_i),
		.en_i(strap_done_ff),
		.phy_addr_i(phy_addr_ff),
		.mdc_i(mdc_i),
		.mdio_i(mdio_i),
		.rdata_i(rd_word_w),
		.mdio_o(mdio_o),
		.mdio_oe_n_o(mdio_oe_n_o),
		.wr_stb_o(wr_stb_w),
		.wdata_o(wdata_w)
	);

	// Read word: upper bits belong to the neighbouring control logic
	assign rd_word_w = {ctrl_hi_i, isolate_ff, restart_ff, duplex_ff, coltest_ff, {pbc_pkg::RSVD_W{1'b0}}};

	// Straps settle through the samplers and the filter before they are trusted, else a set strap reads as zero
	assign strap_load_w = !strap_done_ff && (strap_cnt_ff == pbc_pkg::STRAP_WAIT);

	// Write data on bits 6:0 is dropped; software is expected to write zeros there
	assign nxt_isolate = strap_load_w ? (filt_ff[10:6] == pbc_pkg::STRAP_ZERO)
		: (wr_stb_w ? wdata_w[pbc_pkg::ISOLATE_POS] : isolate_ff);

	// A write of one wins over the engine's start in the same cycle
	assign nxt_restart = (wr_stb_w) ? (wdata_w[pbc_pkg::RESTART_POS] & an_enable_i)
		: (an_started_i ? 1'b0 : restart_ff);

	assign tx_en_w = filt_ff[4] & ~isolate_ff;

	// Control bits
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			strap_cnt_ff <= 3'h0;
			strap_done_ff <= 1'b0;
			phy_addr_ff <= pbc_pkg::STRAP_ZERO;
			isolate_ff <= pbc_pkg::ISOLATE_RST;
			restart_ff <= pbc_pkg::RESTART_RST;
			duplex_ff <= pbc_pkg::DUPLEX_RST;
			coltest_ff <= pbc_pkg::COLTEST_RST;
		end else begin
			if (!strap_done_ff)
				strap_cnt_ff <= strap_cnt_ff + 3'h1;
			if (strap_load_w) begin
				strap_done_ff <= 1'b1;
				phy_addr_ff <= filt_ff[10:6];
			end
			isolate_ff <= nxt_isolate;
			restart_ff <= nxt_restart;
			if (wr_stb_w) begin
				duplex_ff <= wdata_w[pbc_pkg::DUPLEX_POS];
				coltest_ff <= wdata_w[pbc_pkg::COLTEST_POS];
			end
		end
	end

	// Datapath toward core and MAC; every pin is registered
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			core_txd_o <= 4'h0;
			core_tx_en_o <= 1'b0;
			core_tx_er_o <= 1'b0;
			mii_rxd_o <= 4'h0;
			mii_rx_dv_o <= 1'b0;
			mii_rx_er_o <= 1'b0;
			mii_crs_o <= 1'b0;
			mii_col_o <= 1'b0;
			mii_oe_n_o <= 1'b1;
			line_idle_o <= 1'b1;
			alt_tx_oe_n_o <= 1'b1;
			rx_ignore_o <= 1'b1;
			link_disable_o <= 1'b1;
			reference_clock_out_en_o <= 1'b0;
			an_restart_req_o <= 1'b0;
			full_duplex_o <= pbc_pkg::DUPLEX_RST;
			speed_100_o <= 1'b0;
		end else begin
			core_txd_o <= isolate_ff ? 4'h0 : filt_ff[3:0];
			core_tx_en_o <= tx_en_w;
			core_tx_er_o <= filt_ff[5] & ~isolate_ff;
			mii_rxd_o <= core_rxd_i;
			mii_rx_dv_o <= core_rx_dv_i;
			mii_rx_er_o <= core_rx_er_i;
			mii_crs_o <= core_crs_i;
			mii_col_o <= coltest_ff ? tx_en_w : core_col_i;
			mii_oe_n_o <= isolate_ff;
			line_idle_o <= isolate_ff;
			alt_tx_oe_n_o <= isolate_ff;
			rx_ignore_o <= isolate_ff;
			link_disable_o <= isolate_ff;
			reference_clock_out_en_o <= ref_clk_en_i;
			an_restart_req_o <= restart_ff;
			full_duplex_o <= an_enable_i ? an_duplex_i : duplex_ff;
			speed_100_o <= an_enable_i ? an_speed_i : speed_sel_i;
		end
	end

	a_iso_tx_gate: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		isolate_ff |=> !core_tx_en_o && !core_tx_er_o && core_txd_o == 4'h0)
		else $error("transmit input passed while isolated");

	a_iso_mii_float: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		isolate_ff |=> mii_oe_n_o)
		else $error("MII outputs driven while isolated");

	a_iso_refclk_run: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		isolate_ff && ref_clk_en_i |=> reference_clock_out_en_o)
		else $error("reference clock stopped by isolation");

	a_iso_line_state: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		isolate_ff |=> line_idle_o && alt_tx_oe_n_o && rx_ignore_o && link_disable_o)
		else $error("line side not quiet while isolated");

	a_strap_zero_iso: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		$rose(strap_done_ff) |-> isolate_ff == (phy_addr_ff == 5'h00))
		else $error("isolate does not match strapped address");

	a_restart_ignored: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		wr_stb_w && !an_enable_i |=> !restart_ff ##1 !an_restart_req_o)
		else $error("restart accepted with negotiation disabled");

	a_restart_holds: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		restart_ff && !an_started_i && !wr_stb_w |=> restart_ff)
		else $error("restart cleared before engine start");

	a_restart_clears: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		restart_ff && an_started_i && !wr_stb_w |=> !restart_ff)
		else $error("restart not cleared after engine start");

	a_duplex_manual: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		!an_enable_i |=> full_duplex_o == $past(duplex_ff))
		else $error("manual duplex not applied");

	a_duplex_negotiated: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		an_enable_i |=> full_duplex_o == $past(an_duplex_i) && speed_100_o == $past(an_speed_i))
		else $error("select bits used while negotiating");

	a_col_test_loop: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		coltest_ff && filt_ff[4] && !isolate_ff |=> mii_col_o && core_tx_en_o)
		else $error("collision test did not follow transmit enable");
endmodule

// [test/pbc_mac_model.sv]
`timescale 1ns/1ps
module pbc_mac_model (
	input wire logic ref_clk_i,
	input wire logic mdio_i,
	output logic mdc_o,
	output logic mdio_o,
	output logic mdio_oe_n_o,
	output logic [3:0] txd_o,
	output logic tx_en_o,
	output logic tx_er_o
);
	// Management clock rests low between frames, data line left to its pull-up
	initial begin
		mdc_o = 1'b0;
		mdio_o = 1'b1;
		mdio_oe_n_o = 1'b1;
		txd_o = 4'h0;
		tx_en_o = 1'b0;
		tx_er_o = 1'b0;
	end

	// Six reference clocks a half period keeps the management clock near 3.3 MHz
	task automatic half();
		repeat (6) @(negedge ref_clk_i);
	endtask

	// Two idle ones then 32 bit times; a read lets go of the line from turnaround on
	task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg,
		input logic [15:0] wd, output logic [15:0] rd);
		logic [33:0] bits;
		bits = {2'b11, 2'b01, op, phy, rg, 2'b10, wd};
		rd = 16'h0000;
		for (int i = 33; i >= 0; i--) begin
			@(negedge ref_clk_i);
			mdio_oe_n_o = (op == pbc_pkg::OP_READ) && (i < 18);
			mdio_o = bits[i];
			half();
			// Sampled late in the low phase, long after the device moved its bit
			if (i < 16) begin
				rd[i] = mdio_i;
			end
			mdc_o = 1'b1;
			half();
			mdc_o = 1'b0;
		end
		mdio_oe_n_o = 1'b1;
		half();
	endtask

	// Transmit pins change only at the falling edge
	task automatic mii(input logic en, input logic er, input logic [3:0] d);
		@(negedge ref_clk_i);
		tx_en_o = en;
		tx_er_o = er;
		txd_o = d;
	endtask
endmodule

// [test/test_pbc_basic_control.sv]
`timescale 1ns/1ps
module test_pbc_basic_control;
	logic ref_clk_i, reset_n_i, mdc_i, mdio_i, mdio_o, mdio_oe_n_o, mac_mdio, mac_oe_n;
	logic [4:0] station_address_straps_i, ctrl_hi_i, phy;
	logic an_enable_i, speed_sel_i, an_started_i, an_duplex_i, an_speed_i, ref_clk_en_i;
	logic [3:0] txd_i, core_rxd_i, core_txd_o, mii_rxd_o;
	logic tx_en_i, tx_er_i, core_rx_dv_i, core_rx_er_i, core_crs_i, core_col_i;
	logic core_tx_en_o, core_tx_er_o, mii_rx_dv_o, mii_rx_er_o, mii_crs_o, mii_col_o, mii_oe_n_o;
	logic line_idle_o, alt_tx_oe_n_o, rx_ignore_o, link_disable_o, reference_clock_out_en_o;
	logic an_restart_req_o, full_duplex_o, speed_100_o;
	int err_count = 0;
	int samples_checked = 0;

	// Shared data line: whoever enables drives it, otherwise the pull-up wins
	assign mdio_i = !mdio_oe_n_o ? mdio_o : (!mac_oe_n ? mac_mdio : 1'b1);

	pbc_basic_control i_pbc_basic_control (.ref_clk_i, .reset_n_i, .station_address_straps_i, .mdc_i, .mdio_i,
		.mdio_o, .mdio_oe_n_o, .ctrl_hi_i, .an_enable_i, .speed_sel_i, .an_started_i, .an_duplex_i,
		.an_speed_i, .ref_clk_en_i, .txd_i, .tx_en_i, .tx_er_i, .core_rxd_i, .core_rx_dv_i, .core_rx_er_i,
		.core_crs_i, .core_col_i, .core_txd_o, .core_tx_en_o, .core_tx_er_o, .mii_rxd_o, .mii_rx_dv_o,
		.mii_rx_er_o, .mii_crs_o, .mii_col_o, .mii_oe_n_o, .line_idle_o, .alt_tx_oe_n_o, .rx_ignore_o,
		.link_disable_o, .reference_clock_out_en_o, .an_restart_req_o, .full_duplex_o, .speed_100_o);

	pbc_mac_model i_pbc_mac_model (.ref_clk_i(ref_clk_i), .mdio_i(mdio_i), .mdc_o(mdc_i), .mdio_o(mac_mdio),
		.mdio_oe_n_o(mac_oe_n), .txd_o(txd_i), .tx_en_o(tx_en_i), .tx_er_o(tx_er_i));

	initial begin
		ref_clk_i = 1'b0;
		forever #12.5 ref_clk_i = ~ref_clk_i;
	end

	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Straps are set before reset and held well past their capture
	task automatic rst(input logic [4:0] s);
		station_address_straps_i = s;
		phy = s;
		reset_n_i = 1'b0;
		repeat (3) @(negedge ref_clk_i);
		reset_n_i = 1'b1;
		repeat (12) @(negedge ref_clk_i);
	endtask

	// Write lands six cycles after the frame's last rising edge, before the frame task returns; four more give margin
	task automatic wr(input logic [15:0] d);
		logic [15:0] r;
		i_pbc_mac_model.frame(pbc_pkg::OP_WRITE, phy, pbc_pkg::BMC_OFFSET, d, r);
		repeat (4) @(negedge ref_clk_i);
	endtask

	task automatic rchk(input logic iso, input logic rs, input logic dup, input logic col);
		logic [15:0] r;
		i_pbc_mac_model.frame(pbc_pkg::OP_READ, phy, pbc_pkg::BMC_OFFSET, 16'h0000, r);
		chk(r, {ctrl_hi_i, iso, rs, dup, col, 7'h00});
	endtask

	task automatic grp(input logic [4:0] exp);
		chk({11'h000, mii_oe_n_o, line_idle_o, alt_tx_oe_n_o, rx_ignore_o, link_disable_o}, {11'h000, exp});
	endtask

	// Hang guard
	initial begin
		repeat (100000) @(posedge ref_clk_i);
		err_count++;
		stop_test();
	end

	initial begin
		reset_n_i = 1'b0;
		ctrl_hi_i = 5'h15;
		{an_enable_i, speed_sel_i, an_started_i, an_duplex_i, an_speed_i} = 5'h00;
		ref_clk_en_i = 1'b1;
		core_rxd_i = 4'h5;
		{core_rx_dv_i, core_rx_er_i, core_crs_i, core_col_i} = 4'ha;
		rst(5'h00);
		// Address zero comes up isolated but still answers management
		rchk(1'b1, 1'b0, 1'b1, 1'b0);
		grp(5'h1f);
		chk({15'h0000, reference_clock_out_en_o}, 16'h0001);
		i_pbc_mac_model.mii(1'b1, 1'b1, 4'ha);
		repeat (8) @(negedge ref_clk_i);
		chk({10'h000, core_tx_en_o, core_tx_er_o, core_txd_o}, 16'h0000);
		// Leave isolation, manual half duplex
		wr(16'h0000);
		grp(5'h00);
		chk({10'h000, core_tx_en_o, core_tx_er_o, core_txd_o}, 16'h003a);
		chk({8'h00, mii_rx_dv_o, mii_rx_er_o, mii_crs_o, mii_col_o, mii_rxd_o}, 16'h00a5);
		chk({15'h0000, full_duplex_o}, 16'h0000);
		// Negotiated results override manual selects; control bit stays as written
		an_enable_i = 1'b1;
		an_duplex_i = 1'b1;
		an_speed_i = 1'b1;
		repeat (3) @(negedge ref_clk_i);
		chk({14'h0000, full_duplex_o, speed_100_o}, 16'h0003);
		rchk(1'b0, 1'b0, 1'b0, 1'b0);
		// Collision test loops transmit enable onto collision
		wr(16'h0080);
		chk({15'h0000, mii_col_o}, 16'h0001);
		i_pbc_mac_model.mii(1'b0, 1'b0, 4'h0);
		repeat (8) @(negedge ref_clk_i);
		chk({15'h0000, mii_col_o}, 16'h0000);
		// Restart ignored without negotiation, held until the engine starts
		an_enable_i = 1'b0;
		wr(16'h0200);
		chk({15'h0000, an_restart_req_o}, 16'h0000);
		// Manual selects apply again although the negotiated results still say full duplex and fast
		chk({14'h0000, full_duplex_o, speed_100_o}, 16'h0000);
		rchk(1'b0, 1'b0, 1'b0, 1'b0);
		an_enable_i = 1'b1;
		wr(16'h0200);
		chk({15'h0000, an_restart_req_o}, 16'h0001);
		rchk(1'b0, 1'b1, 1'b0, 1'b0);
		wr(16'h0000);
		rchk(1'b0, 1'b0, 1'b0, 1'b0);
		wr(16'h0200);
		an_started_i = 1'b1;
		@(negedge ref_clk_i);
		an_started_i = 1'b0;
		repeat (3) @(negedge ref_clk_i);
		chk({15'h0000, an_restart_req_o}, 16'h0000);
		rchk(1'b0, 1'b0, 1'b0, 1'b0);
		// Second reset with a non-zero address comes up connected
		rst(5'h05);
		rchk(1'b0, 1'b0, 1'b1, 1'b0);
		grp(5'h00);
		wr(16'h0400);
		grp(5'h1f);
		rchk(1'b1, 1'b0, 1'b0, 1'b0);
		stop_test();
	end
endmodule
